/* bench/rx_eq_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module rx_eq_regs_assertions
  import rx_eq_regs_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int GPIOS = NUM_GPIO
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [PORTS-1:0] raw_mode_i,
  input wire logic [PORTS-1:0] frame_active_signal_i,
  input wire logic [PORTS-1:0] frame_start_o,
  input wire logic [GPIOS-1:0] gpio_out_en_i,
  input wire logic [GPIOS-1:0] gpio_pulldown_en_o,
  input wire logic [PORTS-1:0] backchan_frame_i,
  input wire logic [PORTS-1:0] backchan_inject_o,
  input wire logic [PORTS-1:0] rx_lock_raw_i,
  input wire logic [PORTS-1:0] rx_lock_o,
  input wire logic [PORTS-1:0] encoding_err_i,
  input wire logic [PORTS-1:0] ctrlchan_seq_err_i,
  input wire logic [PORTS-1:0] ctrlchan_crc_err_i,
  input wire logic             irq_o
);
  logic err_any;
  assign err_any = |{encoding_err_i, ctrlchan_seq_err_i, ctrlchan_crc_err_i};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_ctl2;
    reg_rd_i && reg_addr_i == ADDR_EQ_CTL2;
  endsequence
  sequence s_fv_rise;
    !frame_active_signal_i[0] ##1 frame_active_signal_i[0];
  endsequence
  a_pulldown_output: assert property ((gpio_pulldown_en_o & $past(gpio_out_en_i)) == '0)
    else $error("pulldown on output pin");
  a_inject_on_frame: assert property (backchan_inject_o[0] |-> $past(backchan_frame_i[0]))
    else $error("inject without frame");
  a_start_after_active: assert property (s_fv_rise |-> !frame_start_o[0])
    else $error("frame start too early");
  a_start_one_cycle: assert property (frame_start_o[0] |=> !frame_start_o[0])
    else $error("frame start longer than one cycle");
  a_lock_needs_raw: assert property (rx_lock_o[0] |-> $past(rx_lock_raw_i[0]))
    else $error("lock without raw lock");
  a_restart_reads_zero: assert property (s_rd_ctl2 |=> reg_rdata_o[3] == 1'b0 && reg_rdata_o[1:0] == 2'b00)
    else $error("restart bit reads set");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(err_any, 2) || $past(reg_wr_i, 2))
    else $error("irq rose without cause");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_start_needs_run: assert property (frame_start_o[0] |-> $past(frame_active_signal_i[0] && raw_mode_i[0], 2))
    else $error("frame start without frame active");
endmodule // rx_eq_regs_assertions
`default_nettype wire

/* bench/serializer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// remote serializer: self-test flag, back channel frame every 8 cycles
module serializer_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [1:0] bist_i,
  output logic      [1:0] selftest_o,
  output logic      [1:0] frame_o
);
  logic [2:0] cnt_r = 3'h0;
  assign selftest_o = bist_i;
  always @(posedge clk_i) begin
    cnt_r <= cnt_r + 3'h1;
    frame_o <= {2{run_i && cnt_r == 3'h0}};
  end
endmodule // serializer_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
// ==========
// bench top
module tb;
  import rx_eq_regs_pkg::*;
  localparam int WB = 4;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o, v;
  logic [1:0]  raw_mode_i = 2'h0;
  logic [1:0]  frame_active_signal_i = 2'h0;
  logic [1:0]  rx_lock_raw_i = 2'h0;
  logic [1:0]  encoding_err_i = 2'h0;
  logic [1:0]  ctrlchan_seq_err_i = 2'h0;
  logic [1:0]  ctrlchan_crc_err_i = 2'h0;
  logic [1:0]  ser_bist = 2'h0;
  logic [1:0]  frame_start_o, remote_selftest_active_i, backchan_frame_i, backchan_inject_o, rx_lock_o;
  logic [6:0]  gpio_out_en_i = 7'h00;
  logic [6:0]  gpio_pulldown_en_o;
  logic [11:0] eq_setting_o;
  logic        irq_o, bad;
  logic        ser_run = 1'b0;
  logic [31:0] lfsr = 32'h9E3B7068;
  int          fails = 0, n_compared = 0, cyc = 0, n_inj = 0, n_frm = 0, n_fs = 0, k, t0;
  logic [7:0]  ra [11] = '{8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hD0, 8'hD1, 8'hD2, 8'hD4, 8'hD5, 8'hE0};
  logic [7:0]  re [11] = '{8'h74, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h43, 8'h94, 8'h60, 8'hF2, 8'h00};
  logic [7:0]  wa [4] = '{ADDR_PD_DIS, ADDR_FV_MIN, ADDR_RSVD_D6, ADDR_IRQ_EN_HI};
  logic [7:0]  wm [4] = '{8'h7F, 8'hFF, 8'hFF, 8'h07};
  rx_port_equalizer_ctl_regs #(.PORTS(2), .GPIOS(7), .WAIT_BASE_CYC(WB)) i_dut (.sys_clk_i, .rst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .raw_mode_i, .frame_active_signal_i, .frame_start_o,
    .gpio_out_en_i, .gpio_pulldown_en_o, .remote_selftest_active_i, .backchan_frame_i, .backchan_inject_o,
    .rx_lock_raw_i, .rx_lock_o, .eq_setting_o, .encoding_err_i, .ctrlchan_seq_err_i, .ctrlchan_crc_err_i, .irq_o);
  serializer_model i_ser (.clk_i(sys_clk_i), .run_i(ser_run), .bist_i(ser_bist),
    .selftest_o(remote_selftest_active_i), .frame_o(backchan_frame_i));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] byp(input logic [7:0] d);
    return {d[7:5], d[3:1]};
  endfunction
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    n_inj += backchan_inject_o[0];
    n_frm += backchan_frame_i[0];
    n_fs += frame_start_o[0];
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    tick(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    tick(1);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    tick(1);
    reg_rd_i = 1'b0;
    `CHK(n, e, reg_rdata_o)
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(2);
    rst_n_i = 1'b1;
    tick(3);
    `CHK("floor", 6'h02, eq_setting_o[5:0])
    rx_lock_raw_i = 2'h1;
    tick(4);
    `CHK("first lock", 6'h00, eq_setting_o[5:0])
    `CHK("lock", 1'b1, rx_lock_o[0])
    rx_lock_raw_i = 2'h0;
    wr(ADDR_PORT_SEL, 8'h00);
    for (k = 0; k < 11; k++) rchk(ra[k], re[k], "reset");
    for (k = 0; k < 12; k++) begin
      lfsr = nxt(lfsr);
      wr(wa[k % 4], lfsr[7:0]);
      rchk(wa[k % 4], lfsr[7:0] & wm[k % 4], "rw");
    end
    for (k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      gpio_out_en_i = lfsr[14:8];
      wr(ADDR_PD_DIS, lfsr[7:0]);
      tick(1);
      `CHK("pulldown", ~lfsr[14:8] & ~lfsr[6:0], gpio_pulldown_en_o)
    end
    $display("registers done");
    ser_bist = 2'h2;
    wr(ADDR_RSVD_D6, 8'h5A);
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_RSVD_D6, 8'hA5);
    rchk(ADDR_DEBUG, 8'h20, "selftest");
    wr(ADDR_PORT_SEL, 8'h00);
    rchk(ADDR_RSVD_D6, 8'h5A, "port sel");
    rchk(ADDR_DEBUG, 8'h00, "selftest");
    ser_run = 1'b1;
    wr(ADDR_DEBUG, 8'h01);
    n_inj = 0;
    tick(40);
    `CHK("one error", 1, n_inj)
    rchk(ADDR_DEBUG, 8'h00, "one clear");
    wr(ADDR_DEBUG, 8'h02);
    n_inj = 0;
    n_frm = 0;
    tick(40);
    ser_run = 1'b0;
    tick(3);
    `CHK("frames", 5, n_frm)
    `CHK("all errors", n_frm, n_inj)
    wr(ADDR_DEBUG, 8'h00);
    $display("debug done");
    for (k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      v = {lfsr[7:5], 1'b0, lfsr[3:1], 1'b1};
      wr(ADDR_EQ_BYPASS, v);
      tick(1);
      `CHK("manual", byp(v), eq_setting_o[5:0])
      rchk(ADDR_EQUALIZER_CURRENT_SETTING, {2'b00, byp(v)}, "status");
    end
    wr(ADDR_EQ_BYPASS, 8'h60);
    wr(ADDR_EQ_LIMITS, 8'h52);
    wr(ADDR_EQ_CTL2, 8'h2C);
    tick(2);
    `CHK("restart", 6'h02, eq_setting_o[5:0])
    rchk(ADDR_EQ_CTL2, 8'h24, "self clear");
    for (k = 0; k < 40 && eq_setting_o[5:0] !== 6'h03; k++) tick(1);
    t0 = cyc;
    for (k = 0; k < 40 && eq_setting_o[5:0] === 6'h03; k++) tick(1);
    `CHK("step wait", WB * 2, cyc - t0)
    bad = 1'b0;
    repeat (100) begin
      tick(1);
      bad = bad | ((eq_setting_o[5:0] >= 6'h02 && eq_setting_o[5:0] <= 6'h05) !== 1'b1);
    end
    `CHK("limits", 1'b0, bad)
    $display("equalizer done");
    for (k = 0; k < 3; k++) begin
      wr(ADDR_IRQ_EN_HI, 8'h00);
      {encoding_err_i[0], ctrlchan_seq_err_i[0], ctrlchan_crc_err_i[0]} = 3'(1 << k);
      tick(1);
      {encoding_err_i[0], ctrlchan_seq_err_i[0], ctrlchan_crc_err_i[0]} = 3'h0;
      tick(3);
      `CHK("masked", 1'b0, irq_o)
      wr(ADDR_IRQ_EN_HI, 8'(1 << k));
      tick(2);
      `CHK("irq", 1'b1, irq_o)
      if (k < 2) rchk(ADDR_RX_STS1, 8'(1 << k), "pending");
      else wr(ADDR_IRQ_EN_HI, 8'h00);
      tick(3);
      `CHK("irq off", 1'b0, irq_o)
    end
    $display("irq done");
    wr(ADDR_FV_MIN, 8'h05);
    raw_mode_i = 2'h1;
    frame_active_signal_i = 2'h1;
    t0 = cyc;
    n_fs = 0;
    for (k = 0; k < 40 && frame_start_o[0] !== 1'b1; k++) tick(1);
    `CHK("start time", 6, cyc - t0)
    tick(20);
    `CHK("start count", 1, n_fs)
    frame_active_signal_i = 2'h0;
    $display("frame start done");
    finish_test();
  end
endmodule // tb
bind rx_port_equalizer_ctl_regs rx_eq_regs_assertions #(.PORTS(PORTS), .GPIOS(GPIOS)) i_chk (.sys_clk_i, .rst_n_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o, .raw_mode_i, .frame_active_signal_i, .frame_start_o,
  .gpio_out_en_i, .gpio_pulldown_en_o, .backchan_frame_i, .backchan_inject_o, .rx_lock_raw_i, .rx_lock_o,
  .encoding_err_i, .ctrlchan_seq_err_i, .ctrlchan_crc_err_i, .irq_o);
`default_nettype wire

/* src/rx_eq_regs_pkg.sv */
package rx_eq_regs_pkg;

  // ==================================================
  // register offsets
  localparam logic [7:0] ADDR_RSVD_BB      = 8'hBB;
  localparam logic [7:0] ADDR_FV_MIN       = 8'hBC;
  localparam logic [7:0] ADDR_RSVD_BD      = 8'hBD;
  localparam logic [7:0] ADDR_PD_DIS       = 8'hBE;
  localparam logic [7:0] ADDR_RSVD_BF      = 8'hBF;
  localparam logic [7:0] ADDR_DEBUG        = 8'hD0;
  localparam logic [7:0] ADDR_RSVD_D1      = 8'hD1;
  localparam logic [7:0] ADDR_EQ_CTL2      = 8'hD2;
  localparam logic [7:0] ADDR_EQUALIZER_CURRENT_SETTING    = 8'hD3;
  localparam logic [7:0] ADDR_EQ_BYPASS    = 8'hD4;
  localparam logic [7:0] ADDR_EQ_LIMITS    = 8'hD5;
  localparam logic [7:0] ADDR_RSVD_D6      = 8'hD6;
  localparam logic [7:0] ADDR_RSVD_D7      = 8'hD7;
  localparam logic [7:0] ADDR_IRQ_EN_HI    = 8'hD8;
  localparam logic [7:0] ADDR_PORT_SEL     = 8'h4C;
  localparam logic [7:0] ADDR_RX_STS1      = 8'h4D;

  // ==================================================
  // reset values
  localparam logic [7:0] RST_RSVD_BB   = 8'h74;
  localparam logic [7:0] RST_RSVD_D1   = 8'h43;
  localparam logic [7:0] RST_FV_MIN    = 8'h00;
  localparam logic [2:0] RST_LOCK_WAIT = 3'h4;
  localparam logic       RST_FIRST_LK  = 1'b1;
  localparam logic       RST_FLOOR_EN  = 1'b1;
  localparam logic [3:0] RST_FLOOR     = 4'h2;
  localparam logic [3:0] RST_MAX       = 4'hF;
  localparam logic [2:0] RST_STAGE1    = 3'h3;
  localparam logic [2:0] RST_STAGE2    = 3'h0;

  // ==================================================
  // field positions
  localparam int DBG_SELFTEST = 5;
  localparam int DBG_CONT_ERR = 1;
  localparam int DBG_ONE_ERR  = 0;
  localparam int CTL2_RESTART = 3;
  localparam int CTL2_FLOOR   = 2;
  localparam int CTL2_FIRST   = 4;
  localparam int BYP_LOCKMODE = 4;
  localparam int BYP_MANUAL   = 0;
  localparam int IE_ENC       = 2;
  localparam int IE_SEQ       = 1;
  localparam int IE_CRC       = 0;
  localparam int STS1_SEQ     = 1;
  localparam int STS1_CRC     = 0;

  // ==================================================
  // timing: base lock wait 164 us, doubled per code step
  localparam int  CLK_MHZ       = 40;
  localparam int  LOCK_WAIT_US  = 164;
  localparam int  LOCK_WAIT_CYC = LOCK_WAIT_US * CLK_MHZ;

  localparam int  NUM_PORTS     = 2;
  localparam int  NUM_GPIO      = 7;

  typedef enum logic [1:0] {
    EQ_IDLE  = 2'b00,
    EQ_WAIT  = 2'b01,
    EQ_DONE  = 2'b10
  } eq_state_e;

endpackage

/* src/rx_port_equalizer_ctl_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] raw mode: frame start only after frame active held programmed link clock count
// [R2] pull-down on when pin not output, unless its disable bit set
// [R3] debug bit 5 reads remote self-test active flag
// [R4] debug bit 1 injects errors into every back channel frame
// [R5] debug bit 0 injects error into exactly one back channel frame
// [R6] equalizer waits 164 us doubled per code step before next setting
// [R7] first-lock mode bit set restarts adaptation from zero on first lock
// [R8] restart bit 3 restarts adaptation and clears itself
// [R9] floor enable: adaptation starts from floor value instead of zero
// [R10] floor field bits 3:0 gives starting gain when floor enabled
// [R11] maximum field bits 7:4 bounds highest adaptive setting
// [R12] software keeps maximum above floor when floor enabled
// [R13] bypass: setting bits 5:3 from stage one, 2:0 from stage two
// [R14] lock mode bit 4: lock reported only after adaptation finishes
// [R15] enable bit 2 raises interrupt on link encoding error
// [R16] enable bit 1 raises interrupt on control channel sequence error
// [R17] enable bit 0 raises interrupt on control channel checksum error
// [R18] per-port registers reach the port chosen by port select
// [R19] reading status one clears pending checksum and sequence error conditions
// [R20] bypass bit 0: 1 disables adaptation, 0 keeps it active
// [R21] status field shows equalizer setting in use for selected port
module rx_port_equalizer_ctl_regs
  import rx_eq_regs_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int GPIOS = NUM_GPIO,
  parameter int WAIT_BASE_CYC = LOCK_WAIT_CYC
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic      [7:0]           reg_rdata_o,
  input  wire logic [PORTS-1:0]     raw_mode_i,
  input  wire logic [PORTS-1:0]     frame_active_signal_i,
  output logic      [PORTS-1:0]     frame_start_o,
  input  wire logic [GPIOS-1:0]     gpio_out_en_i,
  output logic      [GPIOS-1:0]     gpio_pulldown_en_o,
  input  wire logic [PORTS-1:0]     remote_selftest_active_i,
  input  wire logic [PORTS-1:0]     backchan_frame_i,
  output logic      [PORTS-1:0]     backchan_inject_o,
  input  wire logic [PORTS-1:0]     rx_lock_raw_i,
  output logic      [PORTS-1:0]     rx_lock_o,
  output logic      [PORTS*6-1:0]   eq_setting_o,
  input  wire logic [PORTS-1:0]     encoding_err_i,
  input  wire logic [PORTS-1:0]     ctrlchan_seq_err_i,
  input  wire logic [PORTS-1:0]     ctrlchan_crc_err_i,
  output logic                      irq_o
);

  // ==================================================
  // state
  typedef struct packed {
    logic [7:0]             rdata;
    logic                   irq;
    logic [7:0]             port_sel;
    logic [7:0]             rsvd_bb;
    logic [7:0]             rsvd_bd;
    logic [7:0]             rsvd_bf;
    logic [7:0]             rsvd_d1;
    logic [GPIOS-1:0]       pd_dis;
    logic [GPIOS-1:0]       pd_en;
    logic [PORTS-1:0][7:0]  fv_min;
    logic [PORTS-1:0][7:0]  fv_cnt;
    logic [PORTS-1:0]       fv_done;
    logic [PORTS-1:0]       fs;
    logic [PORTS-1:0][4:0]  dbg_rsvd;
    logic [PORTS-1:0]       cont_err;
    logic [PORTS-1:0]       one_err;
    logic [PORTS-1:0]       inject;
    logic [PORTS-1:0][2:0]  lock_wait;
    logic [PORTS-1:0]       first_lk;
    logic [PORTS-1:0]       floor_en;
    logic [PORTS-1:0][2:0]  stage1;
    logic [PORTS-1:0]       lock_mode;
    logic [PORTS-1:0][2:0]  stage2;
    logic [PORTS-1:0]       manual;
    logic [PORTS-1:0][3:0]  eq_max;
    logic [PORTS-1:0][3:0]  eq_floor;
    logic [PORTS-1:0][7:0]  rsvd_d6;
    logic [PORTS-1:0][7:0]  rsvd_d7;
    logic [PORTS-1:0][2:0]  ie;
    logic [PORTS-1:0][2:0]  pend;
    logic [PORTS-1:0]       seen_lock;
    logic [PORTS-1:0]       lock;
    logic [PORTS-1:0][3:0]  eq_val;
    logic [PORTS-1:0][5:0]  eq_out;
    logic [PORTS-1:0][1:0]  eq_st;
    logic [PORTS-1:0][31:0] wait_cnt;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // ==================================================
  // next state
  always_comb begin
    logic       sel_ok;
    logic [0:0] sp;
    logic [7:0] rd;
    logic [31:0] lim;
    logic [3:0] start;
    logic       restart;
    state_nxt = state_r;
    sel_ok    = (int'(state_r.port_sel) < PORTS);
    sp        = state_r.port_sel[0:0];
    rd        = 8'h00;
    lim       = 32'h0;
    start     = 4'h0;
    restart   = 1'b0;

    // register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_PORT_SEL: state_nxt.port_sel = reg_wdata_i;
        ADDR_RSVD_BB:  state_nxt.rsvd_bb = reg_wdata_i;
        ADDR_RSVD_BD:  state_nxt.rsvd_bd = reg_wdata_i;
        ADDR_RSVD_BF:  state_nxt.rsvd_bf = reg_wdata_i;
        ADDR_PD_DIS:   state_nxt.pd_dis = reg_wdata_i[GPIOS-1:0];
        default: begin
          if (sel_ok) begin // [R18]
            unique case (reg_addr_i)
              ADDR_FV_MIN: state_nxt.fv_min[sp] = reg_wdata_i;
              ADDR_DEBUG: begin
                state_nxt.dbg_rsvd[sp] = {reg_wdata_i[7:6], reg_wdata_i[4:2]};
                state_nxt.cont_err[sp] = reg_wdata_i[DBG_CONT_ERR];
                state_nxt.one_err[sp]  = reg_wdata_i[DBG_ONE_ERR];
              end
              ADDR_EQ_CTL2: begin
                state_nxt.lock_wait[sp] = reg_wdata_i[7:5];
                state_nxt.first_lk[sp]  = reg_wdata_i[CTL2_FIRST];
                state_nxt.floor_en[sp]  = reg_wdata_i[CTL2_FLOOR];
              end
              ADDR_EQ_BYPASS: begin
                state_nxt.stage1[sp]    = reg_wdata_i[7:5];
                state_nxt.lock_mode[sp] = reg_wdata_i[BYP_LOCKMODE];
                state_nxt.stage2[sp]    = reg_wdata_i[3:1];
                state_nxt.manual[sp]    = reg_wdata_i[BYP_MANUAL];
              end
              ADDR_EQ_LIMITS: begin
                state_nxt.eq_max[sp]   = reg_wdata_i[7:4];
                state_nxt.eq_floor[sp] = reg_wdata_i[3:0];
              end
              ADDR_RSVD_D6:   state_nxt.rsvd_d6[sp] = reg_wdata_i;
              ADDR_RSVD_D7:   state_nxt.rsvd_d7[sp] = reg_wdata_i;
              ADDR_IRQ_EN_HI: state_nxt.ie[sp] = reg_wdata_i[2:0];
              default: ;
            endcase
          end
        end
      endcase
    end

    // register reads
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_PORT_SEL: rd = state_r.port_sel;
        ADDR_RSVD_BB:  rd = state_r.rsvd_bb;
        ADDR_RSVD_BD:  rd = state_r.rsvd_bd;
        ADDR_RSVD_BF:  rd = state_r.rsvd_bf;
        ADDR_RSVD_D1:  rd = state_r.rsvd_d1;
        ADDR_PD_DIS:   rd = {1'b0, state_r.pd_dis};
        default: begin
          if (sel_ok) begin
            unique case (reg_addr_i)
              ADDR_FV_MIN: rd = state_r.fv_min[sp];
              ADDR_DEBUG: rd = {state_r.dbg_rsvd[sp][4:3],
                                remote_selftest_active_i[sp], // [R3]
                                state_r.dbg_rsvd[sp][2:0],
                                state_r.cont_err[sp], state_r.one_err[sp]};
              ADDR_EQ_CTL2: rd = {state_r.lock_wait[sp], state_r.first_lk[sp],
                                  1'b0, state_r.floor_en[sp], 2'b00};
              ADDR_EQUALIZER_CURRENT_SETTING: rd = {2'b00, state_r.eq_out[sp]}; // [R21]
              ADDR_EQ_BYPASS: rd = {state_r.stage1[sp], state_r.lock_mode[sp],
                                    state_r.stage2[sp], state_r.manual[sp]};
              ADDR_EQ_LIMITS: rd = {state_r.eq_max[sp], state_r.eq_floor[sp]};
              ADDR_RSVD_D6:   rd = state_r.rsvd_d6[sp];
              ADDR_RSVD_D7:   rd = state_r.rsvd_d7[sp];
              ADDR_IRQ_EN_HI: rd = {5'h00, state_r.ie[sp]};
              ADDR_RX_STS1:   rd = {6'h00, state_r.pend[sp][IE_SEQ], state_r.pend[sp][IE_CRC]};
              default:        rd = 8'h00;
            endcase
          end
        end
      endcase
      state_nxt.rdata = rd;
    end

    // gpio pull-downs
    state_nxt.pd_en = ~gpio_out_en_i & ~state_r.pd_dis; // [R2]

    for (int p = 0; p < PORTS; p++) begin
      // frame start gating in raw mode
      state_nxt.fs[p] = 1'b0;
      if (!frame_active_signal_i[p] || !raw_mode_i[p]) begin
        state_nxt.fv_cnt[p]  = 8'h00;
        state_nxt.fv_done[p] = 1'b0;
      end else if (!state_r.fv_done[p]) begin
        if (state_r.fv_cnt[p] >= state_r.fv_min[p]) begin // [R1]
          state_nxt.fs[p]      = 1'b1;
          state_nxt.fv_done[p] = 1'b1;
        end else begin
          state_nxt.fv_cnt[p] = state_r.fv_cnt[p] + 8'h01;
        end
      end

      // back channel error injection
      state_nxt.inject[p] = 1'b0;
      if (backchan_frame_i[p]) begin
        if (state_r.cont_err[p]) begin
          state_nxt.inject[p] = 1'b1; // [R4]
        end else if (state_r.one_err[p]) begin
          state_nxt.inject[p]  = 1'b1; // [R5]
          state_nxt.one_err[p] = 1'b0; // [R5]
        end
      end

      // interrupt pending, set wins over read clear
      if (reg_rd_i && reg_addr_i == ADDR_RX_STS1 && sel_ok && sp == p[0:0]) begin
        state_nxt.pend[p][IE_SEQ] = 1'b0; // [R19]
        state_nxt.pend[p][IE_CRC] = 1'b0; // [R19]
      end
      if (encoding_err_i[p])     state_nxt.pend[p][IE_ENC] = 1'b1;
      if (ctrlchan_seq_err_i[p]) state_nxt.pend[p][IE_SEQ] = 1'b1;
      if (ctrlchan_crc_err_i[p]) state_nxt.pend[p][IE_CRC] = 1'b1;

      // adaptive equalizer
      start = state_r.floor_en[p] ? state_r.eq_floor[p] : 4'h0; // [R9] [R10]
      restart = reg_wr_i && reg_addr_i == ADDR_EQ_CTL2 && sel_ok && sp == p[0:0]
                && reg_wdata_i[CTL2_RESTART]; // [R8]
      lim = 32'(WAIT_BASE_CYC) << state_r.lock_wait[p]; // [R6]
      if (rx_lock_raw_i[p]) state_nxt.seen_lock[p] = 1'b1;
      if (rx_lock_raw_i[p] && !state_r.seen_lock[p] && state_r.first_lk[p]) begin
        state_nxt.eq_val[p]   = 4'h0; // [R7]
        state_nxt.wait_cnt[p] = 32'h0;
        state_nxt.eq_st[p]    = EQ_WAIT;
      end else if (restart || state_r.eq_st[p] == EQ_IDLE) begin
        state_nxt.eq_val[p]   = start; // [R8]
        state_nxt.wait_cnt[p] = 32'h0;
        state_nxt.eq_st[p]    = EQ_WAIT;
      end else if (state_r.eq_st[p] == EQ_WAIT) begin
        if (rx_lock_raw_i[p]) begin
          state_nxt.eq_st[p] = EQ_DONE;
        end else if (state_r.wait_cnt[p] + 32'h1 >= lim) begin
          state_nxt.wait_cnt[p] = 32'h0;
          if (state_r.eq_val[p] >= state_r.eq_max[p]) begin // [R11]
            state_nxt.eq_val[p] = start;
          end else begin
            state_nxt.eq_val[p] = state_r.eq_val[p] + 4'h1;
          end
        end else begin
          state_nxt.wait_cnt[p] = state_r.wait_cnt[p] + 32'h1;
        end
      end else if (!rx_lock_raw_i[p]) begin
        state_nxt.wait_cnt[p] = 32'h0;
        state_nxt.eq_st[p]    = EQ_WAIT;
      end
      if (state_r.manual[p]) begin
        state_nxt.eq_out[p] = {state_r.stage1[p], state_r.stage2[p]}; // [R13] [R20]
      end else begin
        state_nxt.eq_out[p] = {2'b00, state_r.eq_val[p]}; // [R20]
      end
      state_nxt.lock[p] = rx_lock_raw_i[p] &&
        (!state_r.lock_mode[p] || state_r.manual[p] || state_r.eq_st[p] == EQ_DONE); // [R14]
    end

    state_nxt.irq = 1'b0;
    for (int p = 0; p < PORTS; p++) begin
      if (|(state_r.pend[p] & state_r.ie[p])) state_nxt.irq = 1'b1; // [R15] [R16] [R17]
    end
  end

  // ==================================================
  // registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r           <= '0;
      state_r.rsvd_bb   <= RST_RSVD_BB;
      state_r.rsvd_d1   <= RST_RSVD_D1;
      state_r.fv_min    <= {PORTS{RST_FV_MIN}};
      state_r.lock_wait <= {PORTS{RST_LOCK_WAIT}};
      state_r.first_lk  <= {PORTS{RST_FIRST_LK}};
      state_r.floor_en  <= {PORTS{RST_FLOOR_EN}};
      state_r.eq_floor  <= {PORTS{RST_FLOOR}};
      state_r.eq_max    <= {PORTS{RST_MAX}};
      state_r.stage1    <= {PORTS{RST_STAGE1}};
      state_r.stage2    <= {PORTS{RST_STAGE2}};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_o        = state_r.rdata;
  assign irq_o              = state_r.irq;
  assign gpio_pulldown_en_o = state_r.pd_en;
  assign frame_start_o      = state_r.fs;
  assign backchan_inject_o  = state_r.inject;
  assign rx_lock_o          = state_r.lock;
  assign eq_setting_o       = state_r.eq_out;

endmodule // rx_port_equalizer_ctl_regs

`default_nettype wire
